// >>> hdl/mst_pkg.sv
// constants and types shared by the monitor serial target port
package mst_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // link rates the port is built for
  localparam int FS_MAX_KHZ = 400;
  localparam int HS_MAX_KHZ = 2940;
  // spike suppression widths for the two filter settings
  localparam int FS_SPIKE_NS = 50;
  localparam int HS_SPIKE_NS = 10;
  localparam logic [2:0] FS_FILT_CYC = 3'((FS_SPIKE_NS / CLK_PERIOD_NS > 0) ? FS_SPIKE_NS / CLK_PERIOD_NS : 1);
  localparam logic [2:0] HS_FILT_CYC = 3'((HS_SPIKE_NS / CLK_PERIOD_NS > 0) ? HS_SPIKE_NS / CLK_PERIOD_NS : 1);
  // target address layout
  localparam logic [4:0] ADDR_UPPER_A = 5'h10;
  localparam logic [4:0] ADDR_UPPER_B = 5'h12;
  localparam logic [1:0] SEL_GND = 2'h0;
  localparam logic [1:0] SEL_VS = 2'h1;
  localparam logic [1:0] SEL_SDA = 2'h2;
  localparam logic [1:0] SEL_SCL = 2'h3;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] GC_RESET_BYTE = 8'h06;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_IGNORE
  } mst_state_t;

  typedef enum {
    K_DEV_WR, K_DEV_RD, K_GC_WR, K_GC_RD, K_ARA
  } mst_kind_t;
endpackage

// >>> hdl/mst_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ns
`default_nettype none
module mst_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= RST_VAL;
      stable_r <= RST_VAL;
    end else begin
      meta_r <= din;
      stable_r <= meta_r;
    end
  end

  assign dout = stable_r;
endmodule
`default_nettype wire

// >>> hdl/mst_target_port.sv
// two-wire target port: addressing, pointer, word transfer, general call, alert response
// Notes on behaviour
// RQ1: target only; open-drain data and clock
// RQ2: fast mode 400 kHz, high speed 2.94 MHz
// RQ3: words travel upper byte then lower byte
// RQ4: controller sends 7-bit address plus direction
// RQ5: select pin sampled again every transaction
// RQ6: address upper bits per variant, low from pin
// RQ7: first written byte loads the pointer
// RQ8: ack address, pointer, and two data bytes
// RQ9: controller ends writes with start or stop
// RQ10: reads use last pointer; pointer-only write valid
// RQ11: upper byte acked, lower byte maybe not
// RQ12: read ends by nack, start, stop; release
// RQ13: pointer held until next write
// RQ14: no packet error codes, no clock stretching
// RQ15: high-speed code not acked, switches filters
// RQ16: repeated start keeps high speed; stop leaves
// RQ17: general call write 06h gives soft reset
// RQ18: general call read starts a conversion
// RQ19: alerting device answers alert query with address
// RQ20: lost arbitration keeps alert line driven
// RQ21: controller avoids writing reserved pointer locations
// RQ22: unmatched address bytes are nacked and ignored
`timescale 1ns/1ns
`default_nettype none
module mst_target_port #(
  parameter bit VARIANT_B = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelPinIn,
  input wire logic alertActive,
  output logic alertOut,
  output logic alertOe,
  input wire logic [15:0] rdData,
  output logic [7:0] regPtr,
  output logic [15:0] wrData,
  output logic wrStrobe,
  output logic softReset,
  output logic convStart,
  output logic hsMode
);
  import mst_pkg::*;

  logic [2:0] syncOut;
  logic pinS;
  logic [1:0] filt_r, filt_nxt, filtD_r;
  logic [1:0][2:0] fcnt_r, fcnt_nxt;
  logic [2:0] filtLim;
  logic sclF, sdaF, sclRise, sclFall, startDet, stopDet;

  mst_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din({addrSelPinIn, sdaIn, sclIn}),
    .dout(syncOut)
  );
  assign pinS = syncOut[2];

  // spike filter; width follows the speed mode
  always_comb begin
    filt_nxt = filt_r;
    fcnt_nxt = fcnt_r;
    filtLim = hsMode ? HS_FILT_CYC : FS_FILT_CYC; // RQ15 RQ16 RQ2
    for (int i = 0; i < 2; i++) begin
      if (syncOut[i] == filt_r[i]) begin
        fcnt_nxt[i] = 3'h0;
      end else if (fcnt_r[i] >= filtLim - 3'h1) begin
        filt_nxt[i] = syncOut[i];
        fcnt_nxt[i] = 3'h0;
      end else begin
        fcnt_nxt[i] = fcnt_r[i] + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filt_r <= 2'h3;
      filtD_r <= 2'h3;
      fcnt_r <= '0;
    end else begin
      filt_r <= filt_nxt;
      filtD_r <= filt_r;
      fcnt_r <= fcnt_nxt;
    end
  end

  assign sclF = filt_r[0];
  assign sdaF = filt_r[1];
  assign sclRise = sclF & ~filtD_r[0];
  assign sclFall = ~sclF & filtD_r[0];
  assign startDet = sclF & filtD_r[0] & ~sdaF & filtD_r[1];
  assign stopDet = sclF & filtD_r[0] & sdaF & ~filtD_r[1];

  mst_state_t state_r, state_nxt;
  mst_kind_t kind_r, kind_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] rxShift_r, rxShift_nxt, txShift_r, txShift_nxt, rdLo_r, rdLo_nxt;
  logic [7:0] regPtr_r, regPtr_nxt;
  logic [15:0] wrData_r, wrData_nxt;
  logic [1:0] byteIdx_r, byteIdx_nxt;
  logic sdaLow_r, sdaLow_nxt, wrStrobe_r, wrStrobe_nxt, softReset_r, softReset_nxt;
  logic convStart_r, convStart_nxt, hsMode_r, hsMode_nxt;
  logic alertLatch_r, alertLatch_nxt, alertActD_r;
  logic pinA_r, pinA_nxt, pinB_r, pinB_nxt, pinC_r, pinC_nxt;
  logic ack, loadPtr, arbLost, araWin, hsEnter;
  logic [1:0] selBits;
  logic [6:0] ownAddr;

  // pin tied to data or clock is told apart by how it tracks them
  always_comb begin
    if (pinA_r && pinB_r) begin
      selBits = SEL_VS;
    end else if (pinA_r) begin
      selBits = SEL_SCL;
    end else if (pinC_r) begin
      selBits = SEL_SDA;
    end else begin
      selBits = SEL_GND;
    end
    ownAddr = {VARIANT_B ? ADDR_UPPER_B : ADDR_UPPER_A, selBits}; // RQ6
  end

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    bitCnt_nxt = bitCnt_r;
    rxShift_nxt = rxShift_r;
    txShift_nxt = txShift_r;
    rdLo_nxt = rdLo_r;
    regPtr_nxt = regPtr_r;
    wrData_nxt = wrData_r;
    byteIdx_nxt = byteIdx_r;
    sdaLow_nxt = sdaLow_r;
    hsMode_nxt = hsMode_r;
    pinA_nxt = pinA_r;
    pinB_nxt = pinB_r;
    pinC_nxt = pinC_r;
    wrStrobe_nxt = 1'b0;
    softReset_nxt = 1'b0;
    convStart_nxt = 1'b0;
    ack = 1'b0;
    loadPtr = 1'b0;
    arbLost = 1'b0;
    araWin = 1'b0;
    hsEnter = 1'b0;
    if (stopDet) begin
      state_nxt = ST_IDLE;
      sdaLow_nxt = 1'b0; // RQ12 RQ9
      hsMode_nxt = 1'b0; // RQ16
    end else if (startDet) begin
      // repeated start also lands here; speed mode is kept
      state_nxt = ST_ADDR; // RQ16 RQ9 RQ12
      bitCnt_nxt = 4'h0;
      sdaLow_nxt = 1'b0;
      pinA_nxt = pinS; // RQ5
    end else begin
      case (state_r)
        ST_ADDR, ST_RX: begin
          if (sclFall && state_r == ST_ADDR && bitCnt_r == 4'h0) begin
            pinB_nxt = pinS; // RQ5
          end
          if (sclRise) begin
            rxShift_nxt = {rxShift_r[6:0], sdaF};
            bitCnt_nxt = bitCnt_r + 4'h1;
            if (state_r == ST_ADDR && bitCnt_r == 4'h0) begin
              pinC_nxt = pinS; // RQ5
            end
          end else if (sclFall && bitCnt_r == BITS_PER_BYTE) begin
            if (state_r == ST_ADDR) begin
              byteIdx_nxt = 2'h0;
              if (rxShift_r[7:1] == ownAddr) begin
                ack = 1'b1; // RQ8
                kind_nxt = rxShift_r[0] ? K_DEV_RD : K_DEV_WR;
                // word captured at address time so both bytes match
                txShift_nxt = rdData[15:8]; // RQ3 RQ10
                rdLo_nxt = rdData[7:0];
              end else if (rxShift_r[7:1] == GC_ADDR) begin
                ack = 1'b1;
                kind_nxt = rxShift_r[0] ? K_GC_RD : K_GC_WR;
                convStart_nxt = rxShift_r[0]; // RQ18
              end else if (rxShift_r[7:1] == ARA_ADDR && rxShift_r[0] && alertLatch_r) begin
                ack = 1'b1; // RQ19
                kind_nxt = K_ARA;
                txShift_nxt = {ownAddr, 1'b0};
              end else if (rxShift_r[7:3] == HS_CODE_TOP) begin
                hsMode_nxt = 1'b1; // RQ15
                hsEnter = 1'b1;
              end
            end else begin
              if (byteIdx_r != 2'h3) begin
                byteIdx_nxt = byteIdx_r + 2'h1;
              end
              if (kind_r == K_DEV_WR) begin
                case (byteIdx_r)
                  2'h0: begin
                    ack = 1'b1; // RQ7 RQ10
                    loadPtr = 1'b1;
                    regPtr_nxt = rxShift_r; // RQ13
                  end
                  2'h1: begin
                    ack = 1'b1; // RQ3 RQ8
                    wrData_nxt[15:8] = rxShift_r;
                  end
                  2'h2: begin
                    ack = 1'b1; // RQ3 RQ8
                    wrData_nxt[7:0] = rxShift_r;
                    wrStrobe_nxt = 1'b1;
                  end
                  default: ack = 1'b0;
                endcase
              end else if (kind_r == K_GC_WR && byteIdx_r == 2'h0 && rxShift_r == GC_RESET_BYTE) begin
                ack = 1'b1; // RQ17
                softReset_nxt = 1'b1;
                regPtr_nxt = PTR_RESET;
              end
            end
            sdaLow_nxt = ack;
            state_nxt = ack ? ST_ACK : ST_IGNORE; // RQ22
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            sdaLow_nxt = 1'b0;
            bitCnt_nxt = 4'h0;
            case (kind_r)
              K_DEV_WR, K_GC_WR: state_nxt = ST_RX;
              K_DEV_RD, K_ARA: begin
                state_nxt = ST_TX;
                sdaLow_nxt = ~txShift_r[7]; // RQ11
              end
              default: state_nxt = ST_IGNORE;
            endcase
          end
        end
        ST_TX: begin
          if (sclRise) begin
            if (!sdaLow_r && !sdaF) begin
              arbLost = 1'b1; // RQ20
              state_nxt = ST_IGNORE;
            end else begin
              bitCnt_nxt = bitCnt_r + 4'h1;
            end
          end else if (sclFall) begin
            if (bitCnt_r == BITS_PER_BYTE) begin
              sdaLow_nxt = 1'b0;
              state_nxt = ST_TXACK;
              araWin = (kind_r == K_ARA); // RQ19
            end else begin
              txShift_nxt = {txShift_r[6:0], 1'b1};
              sdaLow_nxt = ~txShift_r[6];
            end
          end
        end
        ST_TXACK: begin
          if (sclRise) begin
            rxShift_nxt[0] = sdaF;
          end else if (sclFall) begin
            bitCnt_nxt = 4'h0;
            if (kind_r == K_ARA || rxShift_r[0]) begin
              state_nxt = ST_IGNORE; // RQ12
            end else begin
              state_nxt = ST_TX;
              byteIdx_nxt = 2'h1;
              // past the lower byte the line stays released
              txShift_nxt = (byteIdx_r == 2'h0) ? rdLo_r : IDLE_BYTE; // RQ3 RQ11
              sdaLow_nxt = (byteIdx_r == 2'h0) ? ~rdLo_r[7] : 1'b0;
            end
          end
        end
        ST_IDLE, ST_IGNORE: sdaLow_nxt = 1'b0; // RQ22
        default: state_nxt = ST_IDLE;
      endcase
    end
    // a new alert wins over a clear in the same cycle
    alertLatch_nxt = alertLatch_r;
    if (araWin) begin
      alertLatch_nxt = 1'b0;
    end
    if (alertActive && !alertActD_r) begin
      alertLatch_nxt = 1'b1; // RQ20
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      kind_r <= K_DEV_WR;
      bitCnt_r <= 4'h0;
      rxShift_r <= 8'h00;
      txShift_r <= IDLE_BYTE;
      rdLo_r <= 8'h00;
      regPtr_r <= PTR_RESET;
      wrData_r <= 16'h0000;
      byteIdx_r <= 2'h0;
      sdaLow_r <= 1'b0;
      wrStrobe_r <= 1'b0;
      softReset_r <= 1'b0;
      convStart_r <= 1'b0;
      hsMode_r <= 1'b0;
      alertLatch_r <= 1'b0;
      alertActD_r <= 1'b0;
      pinA_r <= 1'b0;
      pinB_r <= 1'b0;
      pinC_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      bitCnt_r <= bitCnt_nxt;
      rxShift_r <= rxShift_nxt;
      txShift_r <= txShift_nxt;
      rdLo_r <= rdLo_nxt;
      regPtr_r <= regPtr_nxt;
      wrData_r <= wrData_nxt;
      byteIdx_r <= byteIdx_nxt;
      sdaLow_r <= sdaLow_nxt;
      wrStrobe_r <= wrStrobe_nxt;
      softReset_r <= softReset_nxt;
      convStart_r <= convStart_nxt;
      hsMode_r <= hsMode_nxt;
      alertLatch_r <= alertLatch_nxt;
      alertActD_r <= alertActive;
      pinA_r <= pinA_nxt;
      pinB_r <= pinB_nxt;
      pinC_r <= pinC_nxt;
    end
  end

  // clock line is never pulled: no stretching, never a controller
  assign sclOut = 1'b0;
  assign sclOe = 1'b0; // RQ1 RQ14
  assign sdaOut = 1'b0;
  assign sdaOe = sdaLow_r; // RQ1
  assign alertOut = 1'b0;
  assign alertOe = alertLatch_r;
  assign regPtr = regPtr_r;
  assign wrData = wrData_r;
  assign wrStrobe = wrStrobe_r;
  assign softReset = softReset_r;
  assign convStart = convStart_r;
  assign hsMode = hsMode_r;

  property p_no_scl_drive;
    @(posedge clk) disable iff (!reset_n)
    sclOe == 1'b0;
  endproperty
  a_no_scl_drive: assert property (p_no_scl_drive) else $error("clock line driven"); // RQ14

  property p_ptr_load;
    @(posedge clk) disable iff (!reset_n)
    (state_r == ST_RX && kind_r == K_DEV_WR && byteIdx_r == 2'h0 && sclFall && bitCnt_r == BITS_PER_BYTE
      && !startDet && !stopDet) |=> (regPtr == $past(rxShift_r)) && sdaOe;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer byte not loaded and acked"); // RQ7

  property p_ptr_hold;
    @(posedge clk) disable iff (!reset_n)
    (!loadPtr && !softReset_nxt) |=> $stable(regPtr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed without a write"); // RQ13

  property p_wr_ack;
    @(posedge clk) disable iff (!reset_n)
    wrStrobe |-> sdaOe && state_r == ST_ACK && byteIdx_r == 2'h3;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("lower data byte not acked at strobe"); // RQ8

  property p_own_ack;
    @(posedge clk) disable iff (!reset_n)
    (state_r == ST_ADDR && sclFall && bitCnt_r == BITS_PER_BYTE && rxShift_r[7:1] == ownAddr
      && !startDet && !stopDet) |=> sdaOe && state_r == ST_ACK;
  endproperty
  a_own_ack: assert property (p_own_ack) else $error("own address not acked"); // RQ6

  property p_hs_nack;
    @(posedge clk) disable iff (!reset_n)
    hsEnter |=> (!sdaOe && hsMode) [*2];
  endproperty
  a_hs_nack: assert property (p_hs_nack) else $error("high-speed code acked or mode not set"); // RQ15

  property p_hs_stop;
    @(posedge clk) disable iff (!reset_n)
    stopDet |=> !hsMode && !sdaOe && state_r == ST_IDLE;
  endproperty
  a_hs_stop: assert property (p_hs_stop) else $error("stop did not end high-speed mode"); // RQ16

  property p_gc_reset;
    @(posedge clk) disable iff (!reset_n)
    softReset |-> $past(rxShift_r) == GC_RESET_BYTE && $past(kind_r == K_GC_WR) && regPtr == PTR_RESET;
  endproperty
  a_gc_reset: assert property (p_gc_reset) else $error("soft reset without reset command"); // RQ17

  property p_conv_start;
    @(posedge clk) disable iff (!reset_n)
    convStart |-> $past(rxShift_r) == {GC_ADDR, 1'b1} && sdaOe;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("conversion start without general call read"); // RQ18

  property p_arb_lost;
    @(posedge clk) disable iff (!reset_n)
    (arbLost && kind_r == K_ARA) |=> !sdaOe && alertOe;
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("lost arbitration but alert released"); // RQ20

  property p_ignore_release;
    @(posedge clk) disable iff (!reset_n)
    (state_r == ST_IGNORE) |-> !sdaOe;
  endproperty
  a_ignore_release: assert property (p_ignore_release) else $error("data line driven while ignoring"); // RQ22
endmodule
`default_nettype wire

// >>> dv/mst_ctrl_model.sv
// bus controller model: drives the open-drain clock and data lines
`timescale 1ns/1ns
`default_nettype none
module mst_ctrl_model (
  input wire logic clk,
  input wire logic sdaLine,
  output logic sclDrv,
  output logic sdaDrv
);
  // half bit time in clk cycles; 17 gives a 38-cycle bit, just under the top high-speed rate
  int half = 17;
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves a few cycles after the clock fall, never on the same edge
  task automatic start();
    tick(4);
    sdaDrv <= 1'b1;
    tick(half);
    sclDrv <= 1'b1;
    tick(half);
    sdaDrv <= 1'b0;
    tick(half);
    sclDrv <= 1'b0;
  endtask
  task automatic stop();
    tick(4);
    sdaDrv <= 1'b0;
    tick(half);
    sclDrv <= 1'b1;
    tick(half);
    sdaDrv <= 1'b1;
    tick(half);
  endtask
  task automatic bitx(input logic b, output logic s);
    tick(4);
    sdaDrv <= b;
    tick(half);
    sclDrv <= 1'b1;
    tick(half);
    s = sdaLine;
    sclDrv <= 1'b0;
  endtask
  // address byte is seven address bits then the direction bit
  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], s);
    end
    bitx(1'b1, s);
    ack = ~s;
  endtask
  // forceLow pulls chosen bits low, as a rival target would
  task automatic rdByte(input logic ackIt, input logic [7:0] forceLow, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(~forceLow[i], s);
      b[i] = s;
    end
    bitx(~ackIt, s);
  endtask
endmodule
`default_nettype wire

// >>> dv/test_monitor_serial_target_port.sv
// self-checking bench for the monitor serial target port
`timescale 1ns/1ns
`default_nettype none
module test_monitor_serial_target_port;
  import mst_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic alertActive = 1'b0;
  logic [15:0] rdData = 16'h0000;
  logic [1:0] sel = 2'h0;
  logic addrSel;
  logic [31:0] seed = 32'hE141;
  wire logic sclDrv, sdaDrv, sclLine, sdaLine;
  logic sclOut, sclOe, sdaOut, sdaOe, alertOut, alertOe, wrStrobe, softReset, convStart, hsMode;
  logic [7:0] regPtr, lastPtr;
  logic [15:0] wrData, lastWr;
  int fails = 0;
  int check_count = 0;
  int wrCount = 0;
  int rstCount = 0;
  int convCount = 0;
  int clkDriven = 0;
  always #5 clk = ~clk;
  // released lines float to the pull-up
  assign sdaLine = sdaDrv & ~sdaOe;
  assign sclLine = sclDrv & ~sclOe;
  always_comb begin
    case (sel)
      SEL_GND: addrSel = 1'b0;
      SEL_VS: addrSel = 1'b1;
      SEL_SDA: addrSel = sdaLine;
      default: addrSel = sclLine;
    endcase
  end
  always @(posedge clk) begin
    if (wrStrobe === 1'b1) begin
      wrCount++;
      lastWr = wrData;
      lastPtr = regPtr;
    end
    if (softReset === 1'b1) rstCount++;
    if (convStart === 1'b1) convCount++;
    if (sclOe !== 1'b0 || sclOut !== 1'b0 || sdaOut !== 1'b0 || alertOut !== 1'b0) clkDriven++;
  end
  mst_ctrl_model u_mst_ctrl_model (.clk(clk), .sdaLine(sdaLine), .sclDrv(sclDrv), .sdaDrv(sdaDrv));
  mst_target_port #(.VARIANT_B(1'b0)) u_mst_target_port (
    .clk(clk), .reset_n(reset_n), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelPinIn(addrSel),
    .alertActive(alertActive), .alertOut(alertOut), .alertOe(alertOe), .rdData(rdData),
    .regPtr(regPtr), .wrData(wrData), .wrStrobe(wrStrobe), .softReset(softReset),
    .convStart(convStart), .hsMode(hsMode));
  function automatic logic [31:0] nextRnd(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  function automatic logic [6:0] ownAddr(input logic [1:0] s);
    return {ADDR_UPPER_A, s};
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // exp holds the ack expected for the address then each byte
  task automatic wr(input logic [6:0] a, input int n, input logic [23:0] b, input logic [3:0] exp, input bit keep);
    logic ack;
    u_mst_ctrl_model.start();
    u_mst_ctrl_model.wrByte({a, 1'b0}, ack);
    check("write address ack", 16'(ack), 16'(exp[3]));
    for (int i = 0; i < n && exp[3]; i++) begin
      u_mst_ctrl_model.wrByte(b[23-8*i -: 8], ack);
      check("write byte ack", 16'(ack), 16'(exp[2-i]));
    end
    if (!keep) u_mst_ctrl_model.stop();
  endtask
  task automatic rd(input logic [6:0] a, input int n, input logic [7:0] f, input logic exp, output logic [15:0] got);
    logic ack;
    logic [7:0] v;
    got = 16'hFFFF;
    u_mst_ctrl_model.start();
    u_mst_ctrl_model.wrByte({a, 1'b1}, ack);
    check("read address ack", 16'(ack), 16'(exp));
    for (int i = 0; i < n && ack; i++) begin
      u_mst_ctrl_model.rdByte(i == 0 && n > 1, (i == 0) ? f : 8'h00, v);
      got[15-8*i -: 8] = v;
    end
    u_mst_ctrl_model.stop();
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    final_report();
  end
  initial begin
    logic [7:0] ptr;
    logic [15:0] d, got;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    check("reset pointer", 16'(regPtr), 16'(PTR_RESET));
    for (int s = 0; s < 4; s++) begin
      sel <= 2'(s);
      seed = nextRnd(seed);
      // pointers stay inside the defined register set
      ptr = seed[7:0] & 8'h07;
      d = seed[23:8];
      wr(ownAddr(2'(s)), 3, {ptr, d}, 4'hF, 1'b0);
      check("word written", lastWr, d);
      check("word pointer", 16'(lastPtr), 16'(ptr));
      check("write count", 16'(wrCount), 16'(s + 1));
      rdData <= seed[31:16];
      rd(ownAddr(2'(s)), 2, 8'h00, 1'b1, got);
      check("read word", got, seed[31:16]);
      check("data released", 16'(sdaOe), 16'h0000);
      rdData <= ~seed[15:0];
      rd(ownAddr(2'(s)), 2, 8'h00, 1'b1, got);
      check("reread word", got, ~seed[15:0]);
      check("pointer held", 16'(regPtr), 16'(ptr));
      wr({ADDR_UPPER_B, 2'(s)}, 1, 24'h0, 4'h0, 1'b0);
    end
    wr(ownAddr(sel), 1, {8'h05, 16'h0}, 4'hC, 1'b0);
    check("pointer only", 16'(regPtr), 16'h0005);
    wr(ownAddr(sel), 2, {8'h06, 8'hAB, 8'h00}, 4'hE, 1'b0);
    check("no strobe on half word", 16'(wrCount), 16'h0004);
    wr(GC_ADDR, 1, {8'h05, 16'h0}, 4'h8, 1'b0);
    check("no soft reset", 16'(rstCount), 16'h0000);
    wr(GC_ADDR, 1, {GC_RESET_BYTE, 16'h0}, 4'hC, 1'b0);
    check("soft reset", 16'(rstCount), 16'h0001);
    check("pointer after reset", 16'(regPtr), 16'(PTR_RESET));
    rd(GC_ADDR, 0, 8'h00, 1'b1, got);
    check("conversion start", 16'(convCount), 16'h0001);
    rd(ARA_ADDR, 1, 8'h00, 1'b0, got);
    alertActive <= 1'b1;
    repeat (3) @(posedge clk);
    check("alert driven", 16'(alertOe), 16'h0001);
    // only a read may answer the alert query
    wr(ARA_ADDR, 1, 24'h0, 4'h0, 1'b0);
    rd(ARA_ADDR, 1, 8'h80, 1'b1, got);
    check("alert kept after loss", 16'(alertOe), 16'h0001);
    rd(ARA_ADDR, 1, 8'h00, 1'b1, got);
    check("alert reply", 16'(got[15:8]), 16'({ownAddr(sel), 1'b0}));
    check("alert cleared", 16'(alertOe), 16'h0000);
    alertActive <= 1'b0;
    // the high-speed code goes out at the slow rate
    u_mst_ctrl_model.half = 125;
    wr(7'h05, 0, 24'h0, 4'h0, 1'b1);
    check("high speed on", 16'(hsMode), 16'h0001);
    u_mst_ctrl_model.half = 17;
    wr(ownAddr(sel), 3, 24'h02BEEF, 4'hF, 1'b1);
    check("high speed kept", 16'(hsMode), 16'h0001);
    check("high speed word", lastWr, 16'hBEEF);
    u_mst_ctrl_model.stop();
    repeat (20) @(posedge clk);
    check("high speed left", 16'(hsMode), 16'h0000);
    check("clock never driven", 16'(clkDriven), 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
